// *** inc/fns_map.svh ***
// Register map, field positions, reset values and timing of the synthesizer control.
// Assumes a 10 MHz core clock and a 32-bit AHB-Lite register bus.
`ifndef FNS_MAP_SVH
`define FNS_MAP_SVH
// ==========================================
// Offsets (byte addresses)
`define FNS_OFF_SYNTH   8'h00
`define FNS_OFF_REF     8'h04
`define FNS_OFF_STATUS  8'h08
// ==========================================
// Synthesizer word fields
`define FNS_INT_LSB     0
`define FNS_INT_MSB     7
`define FNS_FRAC_LSB    8
`define FNS_FRAC_MSB    22
`define FNS_LOOP_EN_BIT 28
`define FNS_MUX_LSB     29
`define FNS_MUX_MSB     31
// ==========================================
// Reference word fields
`define FNS_RDIV_LSB    4
`define FNS_RDIV_MSB    6
`define FNS_CKDIV_LSB   8
`define FNS_CKDIV_MSB   11
`define FNS_OSC_EN_BIT  12
`define FNS_LOWB_BIT    13
`define FNS_BIAS_LSB    16
`define FNS_BIAS_MSB    19
`define FNS_RECEN_LSB   20
`define FNS_RECEN_MSB   21
// ==========================================
// Reset values
`define FNS_RST_INT     8'h1f
`define FNS_RST_CKDIV   4'h4
`define FNS_RST_RDIV    3'h1
`define FNS_RST_BIAS    4'ha
`define FNS_INT_MIN     8'h1f
// ==========================================
// Timing
`define FNS_CLK_NS      100
`define FNS_REG_UP_NS   50000
`define FNS_REG_UP_CYC  ((`FNS_REG_UP_NS + `FNS_CLK_NS - 1) / `FNS_CLK_NS)
`define FNS_LOCK_IN_NS  8'h0f
`define FNS_LOCK_OUT_NS 8'h19
`define FNS_LOCK_CNT    3'h5
`endif

// *** inc/fns_pkg.sv ***
// Types of the synthesizer control: configuration words, bus request, mux codes.
// Assumes fns_map.svh for all numeric layout.
package fns_pkg;
	typedef enum logic [2:0] {
		FNS_MUX_REG_READY,
		FNS_MUX_DIG_LOCK,
		FNS_MUX_PFD_CLK,
		FNS_MUX_FB_CLK,
		FNS_MUX_LOW
	} fns_mux_t;

	typedef struct packed {
		logic        hsel;
		logic [7:0]  haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
		logic [31:0] hwdata;
	} fns_ahb_req_t;

	typedef struct packed {
		logic [2:0]  mux;
		logic        loop_en;
		logic [14:0] frac;
		logic [7:0]  intn;
	} fns_synth_t;

	typedef struct packed {
		logic [1:0] recen;
		logic [3:0] bias;
		logic       lowb;
		logic       osc_en;
		logic [3:0] ckdiv;
		logic [2:0] rdiv;
	} fns_ref_t;
endpackage

// *** rtl/fns_synth_ctrl.sv ***
// Synthesizer control: AHB-Lite registers, reference select, divided clock,
// reference counter, status mux, digital lock detect, fractional feedback divider.
// Assumes reference, crystal pin and oscillator edges are synchronous levels/pulses.
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "fns_map.svh"
`timescale 1ns/100ps
`default_nettype none
module fns_synth_ctrl (
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 clk_en,
	input  wire logic                 chip_en,
	input  wire fns_pkg::fns_ahb_req_t ahb_req,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 xtal_osc_in,
	input  wire logic                 crystal_pin_two,
	input  wire logic                 synth_osc_tick,
	input  wire logic                 phase_err_valid,
	input  wire logic [7:0]           phase_err_ns,
	output logic                      xtal_osc_run,
	output logic                      regulators_on,
	output logic                      divided_clock_output,
	output logic                      phase_comparator_clock,
	output logic                      feedback_clock,
	output logic                      status_mux_output,
	output logic                      synth_oscillator_run,
	output logic                      low_band_div2,
	output logic [1:0]                synth_recentre,
	output logic [3:0]                synth_bias
);
	import fns_pkg::*;

	// ==========================================
	// Bus slave
	fns_synth_t  synth_q;
	fns_ref_t    ref_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic        reg_ready_q;
	logic        lock_q;
	logic [9:0]  reg_up_cnt_q;

	// Size is not decoded; only whole-word access is supported
	wire logic addr_ph = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

	// Every transfer completes in its first data-phase cycle
	// Transfers offered while clk_en is low are lost; keep it high for bus use
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (clk_en) begin
			wr_pend_q <= addr_ph & ahb_req.hwrite;
			wr_addr_q <= ahb_req.haddr;
		end
	end

	// Write lands in its data phase, one cycle after the address was taken
	function automatic logic wr_hit(
		input logic       pend,
		input logic [7:0] addr,
		input logic [7:0] off
	);
		return pend && (addr == off);
	endfunction

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en && addr_ph && !ahb_req.hwrite) begin
			case (ahb_req.haddr)
				`FNS_OFF_SYNTH: begin
					hrdata <= {synth_q.mux, synth_q.loop_en, 5'h00, synth_q.frac,
						synth_q.intn};
				end
				`FNS_OFF_REF: begin
					hrdata <= {10'h000, ref_q.recen, ref_q.bias, 2'h0, ref_q.lowb,
						ref_q.osc_en, ref_q.ckdiv, 1'b0, ref_q.rdiv, 4'h0};
				end
				`FNS_OFF_STATUS: hrdata <= {30'h0, lock_q, reg_ready_q};
				default:         hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================
	// Configuration; chip enable low returns it to power-up state
	// Writes arriving while chip enable is low are dropped, not deferred
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			synth_q <= '{mux: 3'h0, loop_en: 1'b0, frac: 15'h0000, intn: `FNS_RST_INT};
		end else if (clk_en) begin
			if (!chip_en) begin
				synth_q <= '{mux: 3'h0, loop_en: 1'b0, frac: 15'h0000,
					intn: `FNS_RST_INT};
			end else if (wr_hit(wr_pend_q, wr_addr_q, `FNS_OFF_SYNTH)) begin
				synth_q.intn    <= ahb_req.hwdata[`FNS_INT_MSB:`FNS_INT_LSB];
				synth_q.frac    <= ahb_req.hwdata[`FNS_FRAC_MSB:`FNS_FRAC_LSB];
				synth_q.loop_en <= ahb_req.hwdata[`FNS_LOOP_EN_BIT];
				synth_q.mux     <= ahb_req.hwdata[`FNS_MUX_MSB:`FNS_MUX_LSB];
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_q <= '{recen: 2'h0, bias: `FNS_RST_BIAS, lowb: 1'b0, osc_en: 1'b1,
				ckdiv: `FNS_RST_CKDIV, rdiv: `FNS_RST_RDIV};
		end else if (clk_en) begin
			if (!chip_en) begin
				ref_q <= '{recen: 2'h0, bias: `FNS_RST_BIAS, lowb: 1'b0, osc_en: 1'b1,
					ckdiv: `FNS_RST_CKDIV, rdiv: `FNS_RST_RDIV};
			end else if (wr_hit(wr_pend_q, wr_addr_q, `FNS_OFF_REF)) begin
				ref_q.rdiv   <= ahb_req.hwdata[`FNS_RDIV_MSB:`FNS_RDIV_LSB];
				ref_q.ckdiv  <= ahb_req.hwdata[`FNS_CKDIV_MSB:`FNS_CKDIV_LSB];
				ref_q.osc_en <= ahb_req.hwdata[`FNS_OSC_EN_BIT];
				ref_q.lowb   <= ahb_req.hwdata[`FNS_LOWB_BIT];
				ref_q.bias   <= ahb_req.hwdata[`FNS_BIAS_MSB:`FNS_BIAS_LSB];
				ref_q.recen  <= ahb_req.hwdata[`FNS_RECEN_MSB:`FNS_RECEN_LSB];
			end
		end
	end

	// ==========================================
	// Analog-side controls
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			xtal_osc_run         <= 1'b0;
			regulators_on        <= 1'b0;
			synth_oscillator_run <= 1'b0;
			low_band_div2        <= 1'b0;
			synth_recentre       <= 2'h0;
			synth_bias           <= `FNS_RST_BIAS;
		end else if (clk_en) begin
			xtal_osc_run         <= chip_en & ref_q.osc_en;
			regulators_on        <= chip_en;
			synth_oscillator_run <= chip_en & synth_q.loop_en;
			low_band_div2        <= ref_q.lowb;
			synth_recentre       <= ref_q.recen;
			synth_bias           <= ref_q.bias;
		end
	end

	// ==========================================
	// Regulator ready: counts the settle time after chip enable rises
	// Count parks at its end value so ready holds until chip enable drops
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_up_cnt_q <= 10'h000;
			reg_ready_q  <= 1'b0;
		end else if (clk_en) begin
			if (!chip_en) begin
				reg_up_cnt_q <= 10'h000;
				reg_ready_q  <= 1'b0;
			end else if (reg_up_cnt_q == 10'(`FNS_REG_UP_CYC - 1)) begin
				reg_ready_q  <= 1'b1;
			end else begin
				reg_up_cnt_q <= reg_up_cnt_q + 10'h001;
			end
		end
	end

	// ==========================================
	// Reference select and edge detect
	// Previous sample resets low, the idle level of both sources: no false edge
	logic ref_prev_q;
	wire logic ref_lvl  = ref_q.osc_en ? (xtal_osc_in & chip_en) : crystal_pin_two;
	wire logic ref_rise = ref_lvl & ~ref_prev_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_prev_q <= 1'b0;
		end else if (clk_en) begin
			ref_prev_q <= ref_lvl;
		end
	end

	// ==========================================
	// Divided clock: toggles every ckdiv reference edges, so ratio is 2*ckdiv
	logic [3:0] ck_cnt_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ck_cnt_q             <= 4'h0;
			divided_clock_output <= 1'b0;
		end else if (clk_en) begin
			if (ref_q.ckdiv == 4'h0 || !chip_en) begin
				ck_cnt_q             <= 4'h0;
				divided_clock_output <= 1'b0;
			end else if (ref_rise) begin
				if (ck_cnt_q >= ref_q.ckdiv - 4'h1) begin
					ck_cnt_q             <= 4'h0;
					divided_clock_output <= ~divided_clock_output;
				end else begin
					ck_cnt_q <= ck_cnt_q + 4'h1;
				end
			end
		end
	end

	// ==========================================
	// Reference counter; a ratio of zero behaves as one
	logic [2:0] r_cnt_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			r_cnt_q                <= 3'h0;
			phase_comparator_clock <= 1'b0;
		end else if (clk_en) begin
			phase_comparator_clock <= 1'b0;
			if (ref_rise) begin
				if (r_cnt_q + 3'h1 >= ref_q.rdiv) begin
					r_cnt_q                <= 3'h0;
					phase_comparator_clock <= 1'b1;
				end else begin
					r_cnt_q <= r_cnt_q + 3'h1;
				end
			end
		end
	end

	// ==========================================
	// Digital lock detect
	// An error equal to the release threshold counts as a lost lock
	logic [2:0] lk_cnt_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lk_cnt_q <= 3'h0;
			lock_q   <= 1'b0;
		end else if (clk_en) begin
			if (!synth_q.loop_en || !chip_en) begin
				lk_cnt_q <= 3'h0;
				lock_q   <= 1'b0;
			end else if (phase_err_valid) begin
				if (lock_q) begin
					if (phase_err_ns >= `FNS_LOCK_OUT_NS) begin
						lock_q   <= 1'b0;
						lk_cnt_q <= 3'h0;
					end
				end else if (phase_err_ns < `FNS_LOCK_IN_NS) begin
					if (lk_cnt_q == `FNS_LOCK_CNT - 3'h1) begin
						lock_q <= 1'b1;
					end
					lk_cnt_q <= lk_cnt_q + 3'h1;
				end else begin
					lk_cnt_q <= 3'h0;
				end
			end
		end
	end

	// ==========================================
	// Feedback divider: first-order accumulator carry stretches one cycle by one
	// Integer values below the floor run at the floor rather than faster
	logic [7:0]  fb_cnt_q;
	logic [14:0] acc_q;
	logic        carry_q;
	logic [15:0] acc_sum;
	logic [8:0]  fb_target;

	always_comb begin
		acc_sum   = {1'b0, acc_q} + {1'b0, synth_q.frac};
		fb_target = (synth_q.intn < `FNS_INT_MIN) ? {1'b0, `FNS_INT_MIN} :
			{1'b0, synth_q.intn};
		fb_target = fb_target + {8'h00, carry_q};
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fb_cnt_q       <= 8'h00;
			acc_q          <= 15'h0000;
			carry_q        <= 1'b0;
			feedback_clock <= 1'b0;
		end else if (clk_en) begin
			feedback_clock <= 1'b0;
			if (!synth_q.loop_en || !chip_en) begin
				fb_cnt_q <= 8'h00;
				acc_q    <= 15'h0000;
				carry_q  <= 1'b0;
			end else if (synth_osc_tick) begin
				if ({1'b0, fb_cnt_q} + 9'h001 >= fb_target) begin
					fb_cnt_q       <= 8'h00;
					feedback_clock <= 1'b1;
					acc_q          <= acc_sum[14:0];
					carry_q        <= acc_sum[15];
				end else begin
					fb_cnt_q <= fb_cnt_q + 8'h01;
				end
			end
		end
	end

	// ==========================================
	// Status mux
	// Codes above three drive the pin low
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_mux_output <= 1'b0;
		end else if (clk_en) begin
			case (fns_mux_t'(synth_q.mux))
				FNS_MUX_REG_READY: status_mux_output <= reg_ready_q;
				FNS_MUX_DIG_LOCK:  status_mux_output <= lock_q;
				FNS_MUX_PFD_CLK:   status_mux_output <= phase_comparator_clock;
				FNS_MUX_FB_CLK:    status_mux_output <= feedback_clock;
				default:           status_mux_output <= 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** verification/fns_ctrl_assertions.sv ***
// Port-level checks of the synthesizer control.
// Assumes fns_pkg is compiled first; bound into every fns_synth_ctrl.
`timescale 1ns/100ps
`default_nettype none
module fns_ctrl_checker (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       clk_en,
	input wire logic       chip_en,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       xtal_osc_run,
	input wire logic       regulators_on,
	input wire logic       phase_comparator_clock,
	input wire logic       feedback_clock,
	input wire logic       status_mux_output,
	input wire logic       synth_oscillator_run,
	input wire logic       low_band_div2,
	input wire logic [1:0] synth_recentre,
	input wire logic [3:0] synth_bias
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ========================
	// Checks
	a_bus_no_wait: assert property (hreadyout && !hresp)
		else $error("bus wait or error");
	a_osc_off_ce: assert property (!chip_en && clk_en |=> !xtal_osc_run)
		else $error("oscillator runs while disabled");
	a_ce_clears: assert property (!chip_en && clk_en |=> ##1
		(!low_band_div2 && synth_recentre == 2'h0 && synth_bias == 4'ha))
		else $error("config kept after chip disable");
	a_reg_follow: assert property (clk_en && !sys_rst |=> regulators_on == $past(chip_en))
		else $error("regulators not following chip enable");
	a_ready_late: assert property ($rose(regulators_on) |-> !status_mux_output)
		else $error("ready shown at regulator start");
	a_pcc_pulse: assert property (phase_comparator_clock && clk_en |=> !phase_comparator_clock)
		else $error("comparison pulse too long");
	// Integer floor of 31 keeps pulses far apart
	a_fb_gap: assert property ($rose(feedback_clock) |=> !feedback_clock [*8])
		else $error("feedback pulses too close");
	a_synth_run_ce: assert property (synth_oscillator_run |-> $past(chip_en))
		else $error("synth oscillator runs while disabled");
	c_mux_rise: cover property ($rose(status_mux_output));
	c_fb_pulse: cover property ($rose(feedback_clock));
	c_osc_stop: cover property ($fell(xtal_osc_run));
endmodule
bind fns_synth_ctrl fns_ctrl_checker chk_i (
	.core_clk, .sys_rst, .clk_en, .chip_en, .hreadyout, .hresp, .xtal_osc_run,
	.regulators_on, .phase_comparator_clock, .feedback_clock, .status_mux_output,
	.synth_oscillator_run, .low_band_div2, .synth_recentre, .synth_bias
);
`default_nettype wire

// *** verification/fns_ref_model.sv ***
// Reference sources facing the control: crystal, external CMOS clock, oscillator ticks.
// Assumes the design's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module fns_ref_model (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic xtal_osc_run,
	output logic      xtal_osc_in,
	output logic      crystal_pin_two,
	output logic      synth_osc_tick
);
	logic [1:0] cnt_q;
	// ========================
	// Sources
	// Crystal only swings while enabled; fastest rate rise detect follows
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			xtal_osc_in <= 1'h0;
			cnt_q       <= 2'h0;
		end else begin
			xtal_osc_in <= xtal_osc_run & ~xtal_osc_in;
			cnt_q       <= cnt_q + 2'h1;
		end
	end
	assign crystal_pin_two = cnt_q[1];
	assign synth_osc_tick  = ~sys_rst;
endmodule
`default_nettype wire

// *** verification/fns_synth_ctrl_tb_top.sv ***
// Self-checking bench: bus tasks drive fns_synth_ctrl beside its reference model.
// Assumes a 10 MHz core clock and the map of fns_map.svh.
`timescale 1ns/100ps
`default_nettype none
module fns_synth_ctrl_tb_top;
	import fns_pkg::*;
	logic         core_clk, sys_rst, clk_en, chip_en, hsel, hwrite, hreadyout, hresp;
	logic         xtal_osc_in, crystal_pin_two, synth_osc_tick, perr_v, xtal_osc_run;
	logic         regulators_on, divided_clock_output, phase_comparator_clock;
	logic         feedback_clock, status_mux_output, synth_oscillator_run, low_band_div2;
	logic [1:0]   htrans, synth_recentre;
	logic [3:0]   synth_bias;
	logic [7:0]   haddr, perr_e;
	logic [31:0]  hwdata, hrdata, rd;
	fns_ahb_req_t ahb_req;
	int           miscompares, total_checks, n, r;
	int           ck[2] = '{1, 15};
	assign ahb_req = {hsel, haddr, htrans, hwrite, 3'h2, hreadyout, hwdata};
	fns_synth_ctrl uut (
		.core_clk, .sys_rst, .clk_en, .chip_en, .ahb_req, .hreadyout, .hresp, .hrdata,
		.xtal_osc_in, .crystal_pin_two, .synth_osc_tick, .phase_err_valid(perr_v),
		.phase_err_ns(perr_e), .xtal_osc_run, .regulators_on, .divided_clock_output,
		.phase_comparator_clock, .feedback_clock, .status_mux_output,
		.synth_oscillator_run, .low_band_div2, .synth_recentre, .synth_bias
	);
	fns_ref_model src (
		.core_clk, .sys_rst, .xtal_osc_run, .xtal_osc_in, .crystal_pin_two, .synth_osc_tick
	);
	initial core_clk = 1'h0;
	always #50 core_clk = ~core_clk;
	// ========================
	// Tasks
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task hold;
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (hreadyout !== 1'h1 && k < 20);
		if (k >= 20) begin
			chk(0, 1);
			wrap_up;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hold;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		hold;
		rd = hrdata;
	endtask
	// Cycles between two rises of a divider output
	task rise(input int s);
		logic p, c;
		c = 1'h1;
		n = 0;
		do begin
			@(posedge core_clk);
			p = c;
			c = s == 0 ? divided_clock_output : s == 1 ? phase_comparator_clock :
				s == 2 ? feedback_clock : status_mux_output;
			n++;
		end while (!(p === 1'h0 && c === 1'h1) && n < 300);
		if (n >= 300) begin
			chk(0, 1);
			wrap_up;
		end
	endtask
	// Third rise measured: ratio changes may leave one odd period
	task per(input int s, input int e);
		repeat (3) rise(s);
		chk(n, e);
	endtask
	task perr(input logic [7:0] e);
		perr_v <= 1'h1;
		perr_e <= e;
		@(posedge core_clk);
		perr_v <= 1'h0;
		@(posedge core_clk);
	endtask
	task up;
		n = 0;
		while (status_mux_output !== 1'h1 && n < 700) begin
			@(posedge core_clk);
			n++;
		end
		chk(n >= 500 && n < 700, 1);
		if (n >= 700) wrap_up;
	endtask
	function automatic logic [31:0] refw(logic [2:0] r, logic [3:0] c, logic o, logic b);
		return {12'h0, 4'ha, 2'h0, b, o, c, 1'h0, r, 4'h0};
	endfunction
	// ========================
	// Sequence
	initial begin
		sys_rst = 1'h1;
		clk_en = 1'h1;
		chip_en = 1'h1;
		hsel = 1'h0;
		hwrite = 1'h0;
		htrans = 2'h0;
		haddr = 8'h00;
		hwdata = 32'h0;
		perr_v = 1'h0;
		perr_e = 8'h00;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'h0;
		up;
		chk({xtal_osc_run, synth_bias}, 5'h1a);
		bus(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h000a1410);
		bus(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0000001f);
		bus(1'h0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		bus(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h1);
		per(0, 16);
		$display("reset test done");
		foreach (ck[i]) begin
			bus(1'h1, 8'h04, refw(3'h1, 4'(ck[i]), 1'h1, 1'h0));
			per(0, 4 * ck[i]);
		end
		bus(1'h1, 8'h04, refw(3'h1, 4'h0, 1'h1, 1'h0));
		repeat (3) @(posedge core_clk);
		for (n = 0; n < 64 && divided_clock_output === 1'h0; n++) @(posedge core_clk);
		chk(n, 64);
		$display("divided clock test done");
		for (r = 1; r < 8; r++) begin
			bus(1'h1, 8'h04, refw(3'(r), 4'h4, 1'h1, 1'h0));
			per(1, 2 * r);
		end
		bus(1'h1, 8'h04, refw(3'h1, 4'h4, 1'h0, 1'h1) | 32'h0030_0000);
		per(1, 4);
		chk({xtal_osc_run, low_band_div2, synth_recentre}, 4'h7);
		$display("reference test done");
		bus(1'h1, 8'h00, 32'h30000028);
		per(2, 40);
		chk(synth_oscillator_run, 1);
		bus(1'h1, 8'h00, 32'h50000028);
		per(3, 4);
		bus(1'h1, 8'h00, 32'h70000028);
		per(3, 40);
		bus(1'h1, 8'h00, 32'h90000028);
		repeat (3) @(posedge core_clk);
		for (n = 0; n < 64 && status_mux_output === 1'h0; n++) @(posedge core_clk);
		chk(n, 64);
		bus(1'h1, 8'h00, 32'h30000005);
		per(2, 31);
		repeat (4) perr(8'h0e);
		perr(8'h0f);
		repeat (4) perr(8'h0e);
		bus(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h1);
		perr(8'h0e);
		bus(1'h0, 8'h08, 32'h0);
		chk({rd[1:0], status_mux_output}, 3'h7);
		perr(8'h18);
		bus(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h3);
		perr(8'h19);
		bus(1'h0, 8'h08, 32'h0);
		chk({rd[1:0], status_mux_output}, 3'h2);
		$display("lock test done");
		chip_en <= 1'h0;
		bus(1'h1, 8'h04, refw(3'h7, 4'h1, 1'h1, 1'h0));
		chk({regulators_on, xtal_osc_run, synth_oscillator_run}, 3'h0);
		chip_en <= 1'h1;
		up;
		bus(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h000a1410);
		bus(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0000001f);
		$display("chip enable test done");
		wrap_up;
	end
endmodule
`default_nettype wire
